/* File: src/quad_output_read_cmd_pkg.sv */
package quad_output_read_cmd_pkg;

  // array geometry and data path
  localparam int ADDR_W = 24;
  localparam int BYTE_W = 8;
  localparam int NIB_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 6;

  // command codes
  localparam logic [7:0] CMD_QUAD_OUTPUT_READ = 8'h6B;
  localparam logic [7:0] CMD_FOUR_LINE_ADDR_READ = 8'hEB;
  localparam logic [7:0] CMD_WORD_READ = 8'hE7;
  localparam logic [7:0] CMD_WRAP_SETUP = 8'h77;
  localparam logic [7:0] CMD_CONT_RESET = 8'hFF;

  // phase lengths in serial clocks
  localparam logic [CNT_W-1:0] SERIAL_OPCODE_CLKS = 6'h08;
  localparam logic [CNT_W-1:0] QUAD_OPCODE_CLKS = 6'h02;
  localparam logic [CNT_W-1:0] SERIAL_ADDR_CLKS = 6'h18;
  localparam logic [CNT_W-1:0] QUAD_ADDR_CLKS = 6'h06;
  localparam logic [CNT_W-1:0] MODE_CLKS = 6'h02;
  localparam logic [CNT_W-1:0] QOUT_DUMMY_CLKS = 6'h08;
  localparam logic [CNT_W-1:0] FOUR_LINE_DUMMY_CLKS = 6'h04;
  localparam logic [CNT_W-1:0] WORD_DUMMY_CLKS = 6'h02;
  localparam logic [CNT_W-1:0] WRAP_SETUP_CLKS = 6'h20;
  localparam logic [CNT_W-1:0] QPI_DUMMY_LOW = 6'h04;
  localparam logic [CNT_W-1:0] QPI_DUMMY_MID = 6'h06;
  localparam logic [CNT_W-1:0] QPI_DUMMY_HIGH = 6'h08;

  // continuation mode byte and wrap settings byte fields
  localparam int MODE_CONT_LSB = 4;
  localparam logic [1:0] MODE_CONT_KEEP = 2'h2;
  localparam int WRAP_DIS_POS = 4;
  localparam int WRAP_LEN_LSB = 5;
  localparam logic WRAP_DIS_RESET = 1'b1;
  localparam logic [1:0] WRAP_LEN_RESET = 2'h0;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_OPCODE = 8'h02,
    ST_ADDR = 8'h04,
    ST_MODE = 8'h08,
    ST_DUMMY = 8'h10,
    ST_DATA = 8'h20,
    ST_WRAP = 8'h40,
    ST_IGNORE = 8'h80
  } phase_e;

  typedef enum logic [1:0] {
    RD_QOUT = 2'h0,
    RD_QUAD = 2'h1,
    RD_WORD = 2'h2
  } read_kind_e;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [NIB_W-1:0] dq;
  } pin_sample_s;

  localparam pin_sample_s PIN_IDLE = '{cs_n: 1'b1, sclk: 1'b0, dq: 4'h0};

endpackage : quad_output_read_cmd_pkg

/* File: src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
  import quad_output_read_cmd_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pins
  input wire pin_sample_s pins_in,
  output pin_sample_s pins_out
);

  pin_sample_s meta_reg;
  pin_sample_s stable_reg;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= PIN_IDLE;
      stable_reg <= PIN_IDLE;
    end
    else
    begin
      meta_reg <= pins_in;
      stable_reg <= meta_reg;
    end
  end

  assign pins_out = stable_reg;

endmodule : pin_sync

/* File: src/byte_fifo.sv */
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic flush_in,
  // fill side
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH):0] level_out
);

  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("byte_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_reg, wr_next;
  logic [PW-1:0] rd_reg, rd_next;
  logic [PW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready_out = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out = mem[rd_reg];
  assign level_out = cnt_reg;

  always_comb
  begin
    push = in_valid_in && in_ready_out && !flush_in;
    pop = out_valid_out && out_ready_in && !flush_in;
    wr_next = push ? wr_reg + 1'b1 : wr_reg;
    rd_next = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    if (flush_in)
    begin
      wr_next = '0;
      rd_next = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  // storage needs no reset; only valid entries are ever read
  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem[wr_reg] <= in_data_in;
    end
  end

endmodule : byte_fifo

/* File: src/quad_read_ctrl.sv */
`timescale 1ns/1ps
//
// Functional notes
// - address sampled on rising clock, data nibbles change on falling clock
// - any start address, increments per byte, wraps to zero at the top
// - quad output read: opcode, serial address, eight dummy, nibble data
// - four-line reads ignored while program, erase or status write busy
// - four-line read: opcode, quad address, two mode plus four dummy, data
// - mode bits five-four one-zero: next transaction skips the opcode
// - other mode bits: leave continuous mode at next chip select cycle
// - continuation reset command clears the mode bits
// - wrap setup: opcode, 24 dummy bits, wrap byte, then deselect
// - wrap enabled: reads other than quad output read wrap in 8, 16, 32 or 64 byte sections
// - wrap disable defaults to one; setting it again restores linear reads
// - four-line command mode reads never wrap
// - four-line command mode dummy count is four, six or eight
// - dummy field 00 and 01 give four, 10 six, 11 eight
// - four-line command mode counts mode clocks as dummy, continuation kept
// - word read: even address, quad enable, two dummy clocks; address bit zero is neither checked nor forced here
// - word read continuation with mode bits one-zero skips the opcode
module quad_read_ctrl
  import quad_output_read_cmd_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // serial link pins
  input wire logic CS_N_IN,
  input wire logic SCLK_IN,
  input wire logic [NIB_W-1:0] DQ_IN,
  output logic [NIB_W-1:0] DQ_OUT,
  output logic [NIB_W-1:0] DQ_OE_OUT,
  // device configuration and status
  input wire logic QUAD_ENABLE_IN,
  input wire logic FOUR_LINE_MODE_IN,
  input wire logic [1:0] DUMMY_SEL_IN,
  input wire logic WRITE_BUSY_IN,
  output logic CONT_MODE_OUT,
  output logic WRAP_DISABLE_OUT,
  output logic [1:0] WRAP_LENGTH_OUT,
  // array read port
  output logic ARRAY_REQ_OUT,
  output logic [ADDR_W-1:0] ARRAY_ADDR_OUT,
  input wire logic ARRAY_VALID_IN,
  input wire logic [BYTE_W-1:0] ARRAY_DATA_IN
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and edge detection
  pin_sample_s raw_pins, pins, prev_reg;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;

  assign raw_pins = '{cs_n: CS_N_IN, sclk: SCLK_IN, dq: DQ_IN};

  pin_sync u_sync (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .pins_in(raw_pins),
    .pins_out(pins)
  );

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      prev_reg <= PIN_IDLE;
    end
    else
    begin
      prev_reg <= pins;
    end
  end

  // dq travels with sclk through the same stages, so samples line up
  assign sclk_rise = pins.sclk && !prev_reg.sclk && !pins.cs_n;
  assign sclk_fall = !pins.sclk && prev_reg.sclk && !pins.cs_n;
  assign cs_fall = !pins.cs_n && prev_reg.cs_n;
  assign cs_rise = pins.cs_n && !prev_reg.cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // byte prefetch buffer
  logic fifo_in_ready, fifo_out_valid, fifo_pop, fifo_flush, fifo_push;
  logic [BYTE_W-1:0] fifo_out_data;
  logic [LW-1:0] fifo_level;

  byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .flush_in(fifo_flush),
    .in_valid_in(fifo_push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(ARRAY_DATA_IN),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_out_data),
    .level_out(fifo_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  phase_e state_reg, state_next;
  read_kind_e kind_reg, kind_next, cont_kind_reg, cont_kind_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next, len_cur, dummy_reg, dummy_next;
  logic [31:0] shift_reg, shift_next;
  logic cont_reg, cont_next;
  logic wrap_dis_reg, wrap_dis_next;
  logic [1:0] wrap_len_reg, wrap_len_next;
  logic fetch_reg, fetch_next;
  logic nib_reg, nib_next;
  logic [BYTE_W-1:0] hold_reg, hold_next;
  logic [NIB_W-1:0] dq_reg, dq_next, oe_reg, oe_next;
  logic load_addr, at_end, serial_in;
  logic [7:0] op;

  always_comb
  begin
    case (state_reg)
      ST_OPCODE: len_cur = FOUR_LINE_MODE_IN ? QUAD_OPCODE_CLKS : SERIAL_OPCODE_CLKS;
      ST_ADDR: len_cur = (kind_reg == RD_QOUT) ? SERIAL_ADDR_CLKS : QUAD_ADDR_CLKS;
      ST_MODE: len_cur = MODE_CLKS;
      ST_DUMMY: len_cur = dummy_reg;
      ST_WRAP: len_cur = WRAP_SETUP_CLKS;
      default: len_cur = SERIAL_OPCODE_CLKS;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    cont_kind_next = cont_kind_reg;
    cnt_next = cnt_reg;
    dummy_next = dummy_reg;
    shift_next = shift_reg;
    cont_next = cont_reg;
    wrap_dis_next = wrap_dis_reg;
    wrap_len_next = wrap_len_reg;
    fetch_next = fetch_reg;
    nib_next = nib_reg;
    hold_next = hold_reg;
    dq_next = dq_reg;
    oe_next = oe_reg;
    load_addr = 1'b0;
    fifo_pop = 1'b0;
    fifo_flush = 1'b0;
    at_end = (cnt_reg == len_cur - 6'h01);
    op = 8'h00;
    // one-line phases take dq0 only; the others take a whole nibble
    serial_in = (state_reg == ST_WRAP) || (state_reg == ST_OPCODE && !FOUR_LINE_MODE_IN)
      || (state_reg == ST_ADDR && kind_reg == RD_QOUT);
    if (cs_rise)
    begin
      state_next = ST_IDLE;
      fetch_next = 1'b0;
      oe_next = '0;
    end
    else if (cs_fall)
    begin
      fifo_flush = 1'b1;
      cnt_next = '0;
      shift_next = '0;
      if (cont_reg && WRITE_BUSY_IN)
      begin
        state_next = ST_IGNORE;
      end
      else if (cont_reg)
      begin
        state_next = ST_ADDR;
        kind_next = cont_kind_reg;
      end
      else
      begin
        state_next = ST_OPCODE;
      end
    end
    else if (sclk_rise && state_reg != ST_DATA && state_reg != ST_IDLE && state_reg != ST_IGNORE)
    begin
      shift_next = serial_in ? {shift_reg[30:0], pins.dq[0]} : {shift_reg[27:0], pins.dq};
      cnt_next = at_end ? '0 : cnt_reg + 6'h01;
      if (at_end)
      begin
        case (state_reg)
          ST_OPCODE:
          begin
            op = shift_next[7:0];
            state_next = ST_IGNORE;
            if (op == CMD_CONT_RESET)
            begin
              cont_next = 1'b0;
            end
            else if (WRITE_BUSY_IN)
            begin
              state_next = ST_IGNORE;
            end
            else if (op == CMD_FOUR_LINE_ADDR_READ && (QUAD_ENABLE_IN || FOUR_LINE_MODE_IN))
            begin
              state_next = ST_ADDR;
              kind_next = RD_QUAD;
            end
            else if (op == CMD_QUAD_OUTPUT_READ && QUAD_ENABLE_IN && !FOUR_LINE_MODE_IN)
            begin
              state_next = ST_ADDR;
              kind_next = RD_QOUT;
            end
            else if (op == CMD_WORD_READ && QUAD_ENABLE_IN && !FOUR_LINE_MODE_IN)
            begin
              state_next = ST_ADDR;
              kind_next = RD_WORD;
            end
            else if (op == CMD_WRAP_SETUP && !FOUR_LINE_MODE_IN)
            begin
              state_next = ST_WRAP;
            end
          end
          ST_ADDR:
          begin
            load_addr = 1'b1;
            fetch_next = 1'b1;
            state_next = (kind_reg == RD_QOUT) ? ST_DUMMY : ST_MODE;
            if (kind_reg == RD_QOUT)
            begin
              dummy_next = QOUT_DUMMY_CLKS;
            end
            else if (kind_reg == RD_WORD)
            begin
              dummy_next = WORD_DUMMY_CLKS;
            end
            else if (FOUR_LINE_MODE_IN)
            begin
              // mode clocks are part of the configured count
              case (DUMMY_SEL_IN)
                2'h2: dummy_next = QPI_DUMMY_MID - MODE_CLKS;
                2'h3: dummy_next = QPI_DUMMY_HIGH - MODE_CLKS;
                default: dummy_next = QPI_DUMMY_LOW - MODE_CLKS;
              endcase
            end
            else
            begin
              dummy_next = FOUR_LINE_DUMMY_CLKS;
            end
          end
          ST_MODE:
          begin
            state_next = ST_DUMMY;
            cont_next = (shift_next[MODE_CONT_LSB +: 2] == MODE_CONT_KEEP);
            cont_kind_next = kind_reg;
          end
          ST_DUMMY:
          begin
            state_next = ST_DATA;
            nib_next = 1'b0;
          end
          ST_WRAP:
          begin
            state_next = ST_IGNORE;
            wrap_dis_next = shift_next[WRAP_DIS_POS];
            wrap_len_next = shift_next[WRAP_LEN_LSB +: 2];
          end
          default:
          begin
            state_next = ST_IGNORE;
          end
        endcase
      end
    end
    else if (sclk_fall && state_reg == ST_DATA)
    begin
      oe_next = '1;
      nib_next = !nib_reg;
      if (!nib_reg)
      begin
        // an empty buffer repeats the last byte rather than stall the link
        fifo_pop = fifo_out_valid;
        hold_next = fifo_out_valid ? fifo_out_data : hold_reg;
        dq_next = fifo_out_valid ? fifo_out_data[7:4] : hold_reg[7:4];
      end
      else
      begin
        dq_next = hold_reg[3:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      state_reg <= ST_IDLE;
      kind_reg <= RD_QUAD;
      cont_kind_reg <= RD_QUAD;
      cnt_reg <= '0;
      dummy_reg <= FOUR_LINE_DUMMY_CLKS;
      shift_reg <= '0;
      cont_reg <= 1'b0;
      wrap_dis_reg <= WRAP_DIS_RESET;
      wrap_len_reg <= WRAP_LEN_RESET;
      fetch_reg <= 1'b0;
      nib_reg <= 1'b0;
      hold_reg <= '0;
      dq_reg <= '0;
      oe_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      cont_kind_reg <= cont_kind_next;
      cnt_reg <= cnt_next;
      dummy_reg <= dummy_next;
      shift_reg <= shift_next;
      cont_reg <= cont_next;
      wrap_dis_reg <= wrap_dis_next;
      wrap_len_reg <= wrap_len_next;
      fetch_reg <= fetch_next;
      nib_reg <= nib_next;
      hold_reg <= hold_next;
      dq_reg <= dq_next;
      oe_reg <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array address counter and fetch request
  logic [ADDR_W-1:0] addr_reg, addr_next, wrap_mask, addr_inc;
  logic req_reg, req_next, wrap_on;
  logic [LW-1:0] level_after;

  always_comb
  begin
    case (wrap_len_reg)
      2'h0: wrap_mask = 24'h000007;
      2'h1: wrap_mask = 24'h00000F;
      2'h2: wrap_mask = 24'h00001F;
      default: wrap_mask = 24'h00003F;
    endcase
    wrap_on = !wrap_dis_reg && !FOUR_LINE_MODE_IN && kind_reg != RD_QOUT;
    fifo_push = req_reg && ARRAY_VALID_IN && fifo_in_ready && !fifo_flush;
    addr_inc = addr_reg + 24'h000001;
    addr_next = addr_reg;
    if (load_addr)
    begin
      addr_next = shift_next[ADDR_W-1:0];
    end
    else if (fifo_push)
    begin
      addr_next = wrap_on ? ((addr_reg & ~wrap_mask) | (addr_inc & wrap_mask)) : addr_inc;
    end
    // keep one slot spare so a beat taken next cycle always fits
    level_after = fifo_level + LW'(fifo_push) - LW'(fifo_pop);
    req_next = fetch_next && !fifo_flush && !load_addr && (level_after <= LW'(FIFO_DEPTH - 2));
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      addr_reg <= '0;
      req_reg <= 1'b0;
    end
    else
    begin
      addr_reg <= addr_next;
      req_reg <= req_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign DQ_OUT = dq_reg;
  assign DQ_OE_OUT = oe_reg;
  assign CONT_MODE_OUT = cont_reg;
  assign WRAP_DISABLE_OUT = wrap_dis_reg;
  assign WRAP_LENGTH_OUT = wrap_len_reg;
  assign ARRAY_REQ_OUT = req_reg;
  assign ARRAY_ADDR_OUT = addr_reg;

endmodule : quad_read_ctrl

/* File: tb/quad_read_ctrl_assertions.sv */
`timescale 1ns/1ps
module quad_read_ctrl_assertions
  import quad_output_read_cmd_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // link pins
  input wire logic CS_N_IN,
  input wire logic SCLK_IN,
  input wire logic [NIB_W-1:0] DQ_OUT,
  input wire logic [NIB_W-1:0] DQ_OE_OUT,
  // status
  input wire logic WRITE_BUSY_IN,
  input wire logic CONT_MODE_OUT,
  input wire logic WRAP_DISABLE_OUT,
  input wire logic [1:0] WRAP_LENGTH_OUT,
  // array port
  input wire logic ARRAY_REQ_OUT,
  input wire logic [ADDR_W-1:0] ARRAY_ADDR_OUT,
  input wire logic ARRAY_VALID_IN
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  ////////////////////////////////////////////////////////////////////////////////
  // busy over a whole frame: set only at the select edge, so busy rising mid-frame is not judged
  logic cs_q_reg;
  logic cs_q_next;
  logic busy_all_reg;
  logic busy_all_next;
  always_comb
  begin
    cs_q_next = CS_N_IN;
    busy_all_next = busy_all_reg;
    if (CS_N_IN || !WRITE_BUSY_IN)
      busy_all_next = 1'b0;
    else if (cs_q_reg)
      busy_all_next = 1'b1;
  end
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      cs_q_reg <= 1'b1;
      busy_all_reg <= 1'b0;
    end
    else
    begin
      cs_q_reg <= cs_q_next;
      busy_all_reg <= busy_all_next;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_oe_group;
    DQ_OE_OUT == 4'h0 || DQ_OE_OUT == 4'hF;
  endproperty
  a_oe_group: assert property (p_oe_group) else $error("data enables split");
  property p_oe_idle;
    CS_N_IN [*6] |-> DQ_OE_OUT == 4'h0;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("lines driven while deselected");
  property p_req_idle;
    CS_N_IN [*6] |-> !ARRAY_REQ_OUT;
  endproperty
  a_req_idle: assert property (p_req_idle) else $error("fetch while deselected");
  property p_busy;
    busy_all_reg |-> DQ_OE_OUT == 4'h0 && !ARRAY_REQ_OUT;
  endproperty
  a_busy: assert property (p_busy) else $error("read served while busy");
  property p_dq_fall;
    DQ_OE_OUT == 4'hF && $past(DQ_OE_OUT) == 4'hF && $changed(DQ_OUT) |-> !SCLK_IN;
  endproperty
  a_dq_fall: assert property (p_dq_fall) else $error("nibble changed with clock high");
  property p_addr_inc;
    ARRAY_REQ_OUT && ARRAY_VALID_IN && WRAP_DISABLE_OUT |=> ARRAY_ADDR_OUT == $past(ARRAY_ADDR_OUT) + 24'h000001;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("address not advanced by one");
  property p_addr_hold;
    ARRAY_REQ_OUT && !ARRAY_VALID_IN |=> $stable(ARRAY_ADDR_OUT);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved without a byte");
  property p_wrap_quiet;
    $changed({WRAP_DISABLE_OUT, WRAP_LENGTH_OUT}) |-> !CS_N_IN;
  endproperty
  a_wrap_quiet: assert property (p_wrap_quiet) else $error("wrap settings moved outside a frame");
  property p_cont_rise;
    $rose(CONT_MODE_OUT) |-> !CS_N_IN;
  endproperty
  a_cont_rise: assert property (p_cont_rise) else $error("continuous mode armed outside a frame");
  property p_reset;
    disable iff (1'b0) !RST_N_IN |=> DQ_OE_OUT == 4'h0 && WRAP_DISABLE_OUT && WRAP_LENGTH_OUT == 2'h0 && !CONT_MODE_OUT;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  c_cont: cover property ($rose(CONT_MODE_OUT));
  c_wrap: cover property ($fell(WRAP_DISABLE_OUT));
  c_busy: cover property (busy_all_reg);
  c_data: cover property ($rose(DQ_OE_OUT[0]));
endmodule : quad_read_ctrl_assertions
bind quad_read_ctrl quad_read_ctrl_assertions u_chk (.CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN),
  .CS_N_IN(CS_N_IN), .SCLK_IN(SCLK_IN), .DQ_OUT(DQ_OUT), .DQ_OE_OUT(DQ_OE_OUT), .WRITE_BUSY_IN(WRITE_BUSY_IN),
  .CONT_MODE_OUT(CONT_MODE_OUT), .WRAP_DISABLE_OUT(WRAP_DISABLE_OUT), .WRAP_LENGTH_OUT(WRAP_LENGTH_OUT),
  .ARRAY_REQ_OUT(ARRAY_REQ_OUT), .ARRAY_ADDR_OUT(ARRAY_ADDR_OUT), .ARRAY_VALID_IN(ARRAY_VALID_IN));

/* File: tb/qspi_host_model.sv */
`timescale 1ns/1ps
module qspi_host_model
  import quad_output_read_cmd_pkg::*;
(
  // resolved lines
  input wire logic [NIB_W-1:0] dq_in,
  // driven pins
  output logic cs_n_out,
  output logic sclk_out,
  output logic [NIB_W-1:0] dq_out,
  output logic oe_out
);
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    dq_out = 4'h0;
    oe_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // clock stands low between frames
  task sel(input logic lo);
    #80 cs_n_out = lo;
    #240;
  endtask : sel
  // w of 0 releases the lines for dummy clocks
  task shift(input logic [31:0] v, input int n, input int w);
    for (int i = 0; i < n; i++)
    begin
      oe_out = (w != 0);
      // spare lines toggle in serial phases so a line slip shows
      dq_out = (w == 4) ? v[31:28] : {~v[31:29], v[31]};
      #80 sclk_out = 1'b1;
      #80 sclk_out = 1'b0;
      v = v << w;
    end
  endtask : shift
  task rd(output logic [7:0] b);
    oe_out = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      #80 b = {b[3:0], dq_in};
      sclk_out = 1'b1;
      #80 sclk_out = 1'b0;
    end
  endtask : rd
endmodule : qspi_host_model

/* File: tb/test_quad_read_ctrl.sv */
`timescale 1ns/1ps
module test_quad_read_ctrl;
  import quad_output_read_cmd_pkg::*;
  logic clk, rst_n, qe, flm, busy, valid, slow, oe_seen, h_cs, h_sclk, h_oe, cont, wdis, req;
  logic [1:0] dsel, wlen;
  logic [NIB_W-1:0] h_dq, dq, fpat, dq_o, dq_oe;
  logic [ADDR_W-1:0] addr;
  logic [BYTE_W-1:0] adata, rb;
  int fail_count, tests_run, busy_cnt;
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : mem
  ////////////////////////////////////////////////////////////////////////////////
  // unowned lines wander so a late sample never matches by luck
  always @(posedge clk) fpat <= ~fpat;
  always @(posedge clk) valid <= #1 (slow ? ~valid : 1'b1);
  always @(posedge clk) if (dq_oe[0] === 1'b1) oe_seen <= 1'b1;
  // a write cycle ends by itself, like the array's own busy timer
  always @(posedge clk) if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
  assign busy = (busy_cnt != 0);
  assign adata = valid ? mem(addr) : ~mem(addr);
  assign dq = (dq_oe & dq_o) | (~dq_oe & {4{h_oe}} & h_dq) | (~dq_oe & ~{4{h_oe}} & fpat);
  quad_read_ctrl u_dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CS_N_IN(h_cs), .SCLK_IN(h_sclk), .DQ_IN(dq),
    .DQ_OUT(dq_o), .DQ_OE_OUT(dq_oe), .QUAD_ENABLE_IN(qe), .FOUR_LINE_MODE_IN(flm), .DUMMY_SEL_IN(dsel),
    .WRITE_BUSY_IN(busy), .CONT_MODE_OUT(cont), .WRAP_DISABLE_OUT(wdis), .WRAP_LENGTH_OUT(wlen),
    .ARRAY_REQ_OUT(req), .ARRAY_ADDR_OUT(addr), .ARRAY_VALID_IN(valid), .ARRAY_DATA_IN(adata));
  qspi_host_model u_host (.dq_in(dq), .cs_n_out(h_cs), .sclk_out(h_sclk), .dq_out(h_dq), .oe_out(h_oe));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task end_sim;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task cfg(input logic q, input logic f, input logic b, input logic [1:0] d);
    @(posedge clk);
    #1;
    qe = q;
    flm = f;
    busy_cnt = b ? 1000 : 0;
    dsel = d;
  endtask : cfg
  // ow or aw of 1 sends serially, 4 on all lines; ow of 0 skips the opcode
  task xfer(input logic [7:0] op, input int ow, input logic [23:0] a, input int aw, input logic [7:0] m,
    input int mc, input int dum, input int n, input int wsz, input logic refd);
    logic [23:0] e;
    oe_seen = 1'b0;
    u_host.sel(1'b0);
    if (ow != 0)
      u_host.shift({op, 24'h0}, 8 / ow, ow);
    u_host.shift({a, 8'h0}, 24 / aw, aw);
    u_host.shift({m, 24'h0}, mc, 4);
    u_host.shift(32'h0, dum, 0);
    for (int i = 0; i < n; i++)
    begin
      u_host.rd(rb);
      e = (wsz == 0) ? 24'(a + i) : 24'((a & ~(wsz - 1)) | ((a + i) & (wsz - 1)));
      if (!refd)
        check("byte", rb, mem(e));
    end
    u_host.sel(1'b1);
    if (refd)
      check("refused", oe_seen, 1'b0);
  endtask : xfer
  task wrap(input logic [7:0] w);
    u_host.sel(1'b0);
    u_host.shift({CMD_WRAP_SETUP, 24'h0}, 8, 1);
    u_host.shift(32'h0, 24, 1);
    u_host.shift({w, 24'h0}, 8, 1);
    u_host.sel(1'b1);
    check("wrap_dis", wdis, w[WRAP_DIS_POS]);
    check("wrap_len", wlen, w[WRAP_LEN_LSB +: 2]);
  endtask : wrap
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #600000;
    fail_count++;
    end_sim;
  end
  initial
  begin
    {rst_n, qe, flm, dsel, slow, fpat, valid, oe_seen} = 12'h040;
    fail_count = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    cfg(1'b1, 1'b0, 1'b0, 2'h0);
    repeat (4) @(posedge clk);
    #1;
    check("rst", {cont, wdis, wlen, dq_oe}, {1'b0, 1'b1, 2'h0, 4'h0});
    xfer(CMD_QUAD_OUTPUT_READ, 1, 24'hFFFFFE, 1, 8'h00, 0, 8, 3, 0, 1'b0);
    slow = 1'b0;
    cfg(1'b0, 1'b0, 1'b0, 2'h0);
    xfer(CMD_QUAD_OUTPUT_READ, 1, 24'h000010, 1, 8'h00, 0, 8, 2, 0, 1'b1);
    cfg(1'b1, 1'b0, 1'b1, 2'h0);
    xfer(CMD_FOUR_LINE_ADDR_READ, 1, 24'h000020, 4, 8'hF0, 2, 4, 2, 0, 1'b1);
    cfg(1'b1, 1'b0, 1'b0, 2'h0);
    xfer(CMD_FOUR_LINE_ADDR_READ, 1, 24'h123456, 4, 8'hF0, 2, 4, 4, 0, 1'b0);
    check("cont", cont, 1'b0);
    xfer(CMD_FOUR_LINE_ADDR_READ, 1, 24'h00ABCD, 4, 8'h20, 2, 4, 2, 0, 1'b0);
    check("cont", cont, 1'b1);
    xfer(CMD_FOUR_LINE_ADDR_READ, 0, 24'hABCDEF, 4, 8'h00, 2, 4, 2, 0, 1'b0);
    xfer(CMD_FOUR_LINE_ADDR_READ, 1, 24'h000300, 4, 8'h20, 2, 4, 2, 0, 1'b0);
    check("cont", cont, 1'b1);
    // busy at the select edge of a continuous frame: ignored, mode stays armed
    cfg(1'b1, 1'b0, 1'b1, 2'h0);
    xfer(CMD_FOUR_LINE_ADDR_READ, 0, 24'h000600, 4, 8'h00, 2, 4, 2, 0, 1'b1);
    check("cont", cont, 1'b1);
    cfg(1'b1, 1'b0, 1'b0, 2'h0);
    u_host.sel(1'b0);
    u_host.shift({CMD_CONT_RESET, 24'h0}, 8, 1);
    u_host.sel(1'b1);
    check("cont", cont, 1'b0);
    xfer(CMD_WORD_READ, 1, 24'h000ACE, 4, 8'h20, 2, 2, 3, 0, 1'b0);
    xfer(CMD_WORD_READ, 0, 24'h000B00, 4, 8'h00, 2, 2, 2, 0, 1'b0);
    check("cont", cont, 1'b0);
    for (int l = 0; l < 4; l++)
    begin
      wrap({1'b0, 2'(l), 5'h00});
      xfer(CMD_FOUR_LINE_ADDR_READ, 1, 24'(32'h200 + (8 << l) - 2), 4, 8'hF0, 2, 4, 4, 8 << l, 1'b0);
    end
    // wrap stays enabled here: four-line mode must still read linearly
    for (int s = 0; s < 4; s++)
    begin
      cfg(1'b1, 1'b1, 1'b0, 2'(s));
      xfer(CMD_FOUR_LINE_ADDR_READ, 4, 24'h00033E, 4, 8'hF0, 2, (s < 2) ? 2 : 2 * s, 4, 0, 1'b0);
    end
    xfer(CMD_FOUR_LINE_ADDR_READ, 4, 24'h000400, 4, 8'h20, 2, 6, 2, 0, 1'b0);
    xfer(CMD_FOUR_LINE_ADDR_READ, 0, 24'h000500, 4, 8'h00, 2, 6, 2, 0, 1'b0);
    cfg(1'b1, 1'b0, 1'b0, 2'h0);
    wrap(8'h10);
    xfer(CMD_FOUR_LINE_ADDR_READ, 1, 24'h00033E, 4, 8'hF0, 2, 4, 4, 0, 1'b0);
    end_sim;
  end
endmodule : test_quad_read_ctrl
